// ### rtl/occ_pkg.sv
// Package: constants and types for the output compare channel
//
// What this block does
// - Idle stop select set freezes compare matches, but not the mode 111 fault reaction, while the CPU idles.
// - Fault flag set by a PWM fault; a software write to the control register clears it unless a fault falls in that cycle and mode 111 is rewritten.
// - Fault flag only meaningful in mode 111; otherwise stays clear.
// - Time base select 1 picks the second timer, 0 the first.
// - Mode 111 gives PWM with the fault input monitored.
// - Mode 110 gives PWM with the fault input ignored.
// - Mode 101 starts low, then makes continuous pulses from matches.
// - Mode 100 starts low, then makes exactly one pulse.
// - Mode 011 toggles the pin on every compare match.
// - Mode 010 starts high and forces low on a match.
// - Mode 001 starts low and forces high on a match.
// - Mode 000 disables the channel: no drive, no match reaction.
// - Control bits 15-14 and 12-5 always read as zero.
// - Interrupt per mode: edge of pin, none in 110, fault fall in 111.
// - PWM pin starts 0 if primary value zero, else 1.
package occ_pkg;

  localparam logic [1:0] OCC_ADDR_CTRL = 2'h0;
  localparam logic [1:0] OCC_ADDR_PRI = 2'h1;
  localparam logic [1:0] OCC_ADDR_SEC = 2'h2;
  localparam logic [15:0] OCC_CTRL_RESET = 16'h0000;
  localparam logic [15:0] OCC_CMP_RESET = 16'h0000;
  localparam int OCC_BIT_IDLE = 13;
  localparam int OCC_BIT_FLT = 4;
  localparam int OCC_BIT_TSEL = 3;
  localparam logic [15:0] OCC_CTRL_WMASK = 16'h200f;

  typedef enum logic [2:0] {
    OCC_M_OFF = 3'h0,
    OCC_M_RISE = 3'h1,
    OCC_M_FALL = 3'h2,
    OCC_M_TOG = 3'h3,
    OCC_M_ONE = 3'h4,
    OCC_M_CONT = 3'h5,
    OCC_M_PWM = 3'h6,
    OCC_M_PWMF = 3'h7
  } occ_mode_t;

  typedef struct packed {
    logic tick;
    logic [15:0] count;
    logic [15:0] period;
  } occ_timer_t;

  typedef struct packed {
    logic idle_stop_select;
    logic timebase_select;
    occ_mode_t compare_mode_field;
  } occ_ctrl_t;

endpackage

// ### rtl/occ_sync.sv
// Two-flop synchroniser for one pin input
`timescale 1ns/10ps
module occ_sync
  import occ_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // Data
  input wire logic i_d,
  output logic o_q
);

  logic meta_r;
  logic meta_nxt;
  logic q_nxt;

  always_comb begin
    meta_nxt = i_d;
    q_nxt = meta_r;
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      // Idle level of the active-low fault pin, so no false edge
      meta_r <= 1'b1;
      o_q <= 1'b1;
    end else begin
      meta_r <= meta_nxt;
      o_q <= q_nxt;
    end
  end

endmodule

// ### rtl/occ_channel.sv
// Output compare channel: registers, match logic, pin and event
`timescale 1ns/10ps
module occ_channel
  import occ_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // Register port
  input wire logic [1:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // Time bases
  input wire occ_timer_t i_first_timer,
  input wire occ_timer_t i_second_timer,
  // System state and fault pin
  input wire logic i_cpu_idle,
  input wire logic i_fault_input_a_n,
  // Pin and event
  output logic o_compare_output_pin,
  output logic o_compare_output_pin_oe_n,
  output logic o_compare_event
);

  occ_ctrl_t ctrl_r, ctrl_nxt;
  logic flt_r, flt_nxt;
  logic [15:0] pri_r, pri_nxt;
  logic [15:0] sec_r, sec_nxt;
  logic [15:0] rdata_nxt;
  logic pin_nxt, oe_n_nxt, evt_nxt;
  logic armed_r, armed_nxt;
  logic flt_s, flt_prev_r;
  logic run, tick, pri_hit, sec_hit, per_hit, flt_fall;
  logic [15:0] count;
  logic [15:0] period;
  logic [15:0] ctrl_rd;

  occ_sync u_flt_sync (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_d(i_fault_input_a_n),
    .o_q(flt_s)
  );

  // Time base select and match detection
  always_comb begin
    run = !(ctrl_r.idle_stop_select && i_cpu_idle);
    if (ctrl_r.timebase_select) begin
      tick = i_second_timer.tick;
      count = i_second_timer.count;
      period = i_second_timer.period;
    end else begin
      tick = i_first_timer.tick;
      count = i_first_timer.count;
      period = i_first_timer.period;
    end
    pri_hit = run && tick && (count == pri_r);
    sec_hit = run && tick && (count == sec_r);
    per_hit = run && tick && (count == period);
    flt_fall = flt_prev_r && !flt_s;
    ctrl_rd = 16'h0000;
    ctrl_rd[OCC_BIT_IDLE] = ctrl_r.idle_stop_select;
    ctrl_rd[OCC_BIT_FLT] = flt_r;
    ctrl_rd[OCC_BIT_TSEL] = ctrl_r.timebase_select;
    ctrl_rd[2:0] = ctrl_r.compare_mode_field;
  end

  // Register writes and read data
  always_comb begin
    ctrl_nxt = ctrl_r;
    pri_nxt = pri_r;
    sec_nxt = sec_r;
    rdata_nxt = 16'h0000;
    if (i_wr) begin
      case (i_addr)
        OCC_ADDR_CTRL: begin
          ctrl_nxt.idle_stop_select = i_wdata[OCC_BIT_IDLE];
          ctrl_nxt.timebase_select = i_wdata[OCC_BIT_TSEL];
          ctrl_nxt.compare_mode_field = occ_mode_t'(i_wdata[2:0]);
        end
        OCC_ADDR_PRI: pri_nxt = i_wdata;
        OCC_ADDR_SEC: sec_nxt = i_wdata;
        default: ;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        OCC_ADDR_CTRL: rdata_nxt = ctrl_rd;
        OCC_ADDR_PRI: rdata_nxt = pri_r;
        OCC_ADDR_SEC: rdata_nxt = sec_r;
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  wire mode_wr = i_wr && (i_addr == OCC_ADDR_CTRL);
  wire occ_mode_t new_mode = occ_mode_t'(i_wdata[2:0]);

  // Pin, arming and fault state
  always_comb begin
    pin_nxt = o_compare_output_pin;
    oe_n_nxt = o_compare_output_pin_oe_n;
    armed_nxt = armed_r;
    flt_nxt = flt_r;
    if (mode_wr) begin
      armed_nxt = 1'b1;
      oe_n_nxt = (new_mode == OCC_M_OFF);
      // A fault in the write cycle survives a rewrite of mode 111
      flt_nxt = (ctrl_r.compare_mode_field == OCC_M_PWMF) && flt_fall
        && (new_mode == OCC_M_PWMF);
      case (new_mode)
        OCC_M_OFF: pin_nxt = 1'b0;
        OCC_M_RISE: pin_nxt = 1'b0;
        OCC_M_FALL: pin_nxt = 1'b1;
        OCC_M_TOG: pin_nxt = o_compare_output_pin;
        OCC_M_ONE: pin_nxt = 1'b0;
        OCC_M_CONT: pin_nxt = 1'b0;
        OCC_M_PWM: pin_nxt = (pri_nxt != 16'h0000);
        OCC_M_PWMF: pin_nxt = (pri_nxt != 16'h0000);
        default: pin_nxt = 1'b0;
      endcase
      if (flt_nxt) oe_n_nxt = 1'b1;
    end else begin
      case (ctrl_r.compare_mode_field)
        OCC_M_OFF: ;
        OCC_M_RISE: if (pri_hit && armed_r) begin
          pin_nxt = 1'b1;
          armed_nxt = 1'b0;
        end
        OCC_M_FALL: if (pri_hit && armed_r) begin
          pin_nxt = 1'b0;
          armed_nxt = 1'b0;
        end
        OCC_M_TOG: if (pri_hit) pin_nxt = !o_compare_output_pin;
        OCC_M_ONE, OCC_M_CONT: begin
          if (pri_hit && armed_r) pin_nxt = 1'b1;
          else if (sec_hit && o_compare_output_pin) begin
            pin_nxt = 1'b0;
            if (ctrl_r.compare_mode_field == OCC_M_ONE) armed_nxt = 1'b0;
          end
        end
        OCC_M_PWM, OCC_M_PWMF: begin
          if (ctrl_r.compare_mode_field == OCC_M_PWMF && flt_fall) begin
            flt_nxt = 1'b1;
            oe_n_nxt = 1'b1;
          end else if (!flt_r) begin
            if (per_hit) pin_nxt = (pri_r != 16'h0000);
            else if (pri_hit) pin_nxt = 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  // Interrupt event per mode
  always_comb begin
    evt_nxt = 1'b0;
    case (ctrl_r.compare_mode_field)
      OCC_M_RISE: evt_nxt = pin_nxt && !o_compare_output_pin;
      OCC_M_FALL, OCC_M_ONE, OCC_M_CONT:
        evt_nxt = !pin_nxt && o_compare_output_pin;
      OCC_M_TOG: evt_nxt = pin_nxt != o_compare_output_pin;
      OCC_M_PWMF: evt_nxt = flt_fall;
      default: evt_nxt = 1'b0;
    endcase
    if (mode_wr) evt_nxt = 1'b0;
  end

  // State registers
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      ctrl_r.idle_stop_select <= OCC_CTRL_RESET[OCC_BIT_IDLE];
      ctrl_r.timebase_select <= OCC_CTRL_RESET[OCC_BIT_TSEL];
      ctrl_r.compare_mode_field <= occ_mode_t'(OCC_CTRL_RESET[2:0]);
      flt_r <= OCC_CTRL_RESET[OCC_BIT_FLT];
      pri_r <= OCC_CMP_RESET;
      sec_r <= OCC_CMP_RESET;
      o_rdata <= 16'h0000;
      o_compare_output_pin <= 1'b0;
      o_compare_output_pin_oe_n <= 1'b1;
      o_compare_event <= 1'b0;
      armed_r <= 1'b0;
      flt_prev_r <= 1'b1;
    end else begin
      ctrl_r <= ctrl_nxt;
      flt_r <= flt_nxt;
      pri_r <= pri_nxt;
      sec_r <= sec_nxt;
      o_rdata <= rdata_nxt;
      o_compare_output_pin <= pin_nxt;
      o_compare_output_pin_oe_n <= oe_n_nxt;
      o_compare_event <= evt_nxt;
      armed_r <= armed_nxt;
      flt_prev_r <= flt_s;
    end
  end

  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  chk_ctrl_zero_bits: assert property (
    i_rd && i_addr == OCC_ADDR_CTRL |=> o_rdata[15:14] == 2'h0
      && o_rdata[12:5] == 8'h00)
    else $error("reserved control bits read nonzero");
  chk_flt_only_pwmf: assert property (
    ctrl_r.compare_mode_field != OCC_M_PWMF |-> !flt_r)
    else $error("fault flag set outside fault mode");
  chk_flt_sticky: assert property (
    flt_r && !mode_wr |=> flt_r)
    else $error("fault flag cleared without mode change");
  chk_idle_freeze: assert property (
    ctrl_r.idle_stop_select && i_cpu_idle && !mode_wr
      |=> $stable(o_compare_output_pin))
    else $error("pin moved while frozen in idle");
  chk_tog_flip: assert property (
    ctrl_r.compare_mode_field == OCC_M_TOG && pri_hit && !mode_wr
      |=> o_compare_output_pin != $past(o_compare_output_pin))
    else $error("toggle mode missed a match");
  chk_rise_set: assert property (
    ctrl_r.compare_mode_field == OCC_M_RISE && pri_hit && !mode_wr
      |=> o_compare_output_pin ##1 o_compare_output_pin)
    else $error("rise mode did not force high");
  chk_off_undriven: assert property (
    ctrl_r.compare_mode_field == OCC_M_OFF && !mode_wr
      |=> o_compare_output_pin_oe_n)
    else $error("disabled channel drives pin");
  chk_pwm_init: assert property (
    mode_wr && i_wdata[2:1] == 2'h3
      |=> o_compare_output_pin == (pri_r != 16'h0000))
    else $error("PWM start level wrong");
  chk_no_evt_pwm: assert property (
    ctrl_r.compare_mode_field == OCC_M_PWM && !mode_wr
      |=> !o_compare_event)
    else $error("event raised in plain PWM mode");
  chk_tsel_second: assert property (
    ctrl_r.timebase_select |-> pri_hit == (run && i_second_timer.tick
      && i_second_timer.count == pri_r))
    else $error("second timer match not taken");
  chk_tsel_first: assert property (
    !ctrl_r.timebase_select |-> pri_hit == (run && i_first_timer.tick
      && i_first_timer.count == pri_r))
    else $error("first timer match not taken");
  chk_idle_no_match: assert property (
    ctrl_r.idle_stop_select && i_cpu_idle
      |-> !pri_hit && !sec_hit && !per_hit)
    else $error("match taken while frozen in idle");

  // Single-edge and pulse modes
  chk_fall_clear: assert property (
    ctrl_r.compare_mode_field == OCC_M_FALL && pri_hit && !mode_wr
      |=> !o_compare_output_pin)
    else $error("fall mode did not force low");
  chk_pulse_start: assert property (
    ctrl_r.compare_mode_field == OCC_M_CONT && pri_hit && !mode_wr
      |=> o_compare_output_pin)
    else $error("continuous pulse did not start");
  chk_pulse_end: assert property (
    (ctrl_r.compare_mode_field == OCC_M_ONE
      || ctrl_r.compare_mode_field == OCC_M_CONT)
      && sec_hit && !(pri_hit && armed_r) && o_compare_output_pin
      && !mode_wr |=> !o_compare_output_pin)
    else $error("pulse did not end on secondary match");
  chk_one_shot_done: assert property (
    ctrl_r.compare_mode_field == OCC_M_ONE && !armed_r
      && !o_compare_output_pin && !mode_wr |=> !o_compare_output_pin)
    else $error("single pulse mode pulsed twice");

  // PWM and fault
  chk_pwm_period: assert property (
    (ctrl_r.compare_mode_field == OCC_M_PWM
      || ctrl_r.compare_mode_field == OCC_M_PWMF)
      && !flt_r && !flt_fall && per_hit && !mode_wr
      |=> o_compare_output_pin == ($past(pri_r) != 16'h0000))
    else $error("PWM period start level wrong");
  chk_pwm_duty_end: assert property (
    (ctrl_r.compare_mode_field == OCC_M_PWM
      || ctrl_r.compare_mode_field == OCC_M_PWMF)
      && !flt_r && !flt_fall && pri_hit && !per_hit && !mode_wr
      |=> !o_compare_output_pin)
    else $error("PWM duty did not end on match");
  chk_flt_release: assert property (
    ctrl_r.compare_mode_field == OCC_M_PWMF && flt_fall && !mode_wr
      |=> flt_r && o_compare_output_pin_oe_n)
    else $error("fault did not set flag and release pin");
  chk_pwm_ignore: assert property (
    ctrl_r.compare_mode_field == OCC_M_PWM && flt_fall && !mode_wr
      |=> !o_compare_output_pin_oe_n)
    else $error("plain PWM reacted to the fault input");

  // Events
  chk_evt_rise: assert property (
    ctrl_r.compare_mode_field == OCC_M_RISE && !$past(mode_wr)
      && $rose(o_compare_output_pin) |-> o_compare_event)
    else $error("no event on rise mode edge");
  chk_evt_fall: assert property (
    (ctrl_r.compare_mode_field == OCC_M_FALL
      || ctrl_r.compare_mode_field == OCC_M_ONE
      || ctrl_r.compare_mode_field == OCC_M_CONT)
      && !$past(mode_wr) && $fell(o_compare_output_pin)
      |-> o_compare_event)
    else $error("no event on falling pin edge");
  chk_off_no_evt: assert property (
    ctrl_r.compare_mode_field == OCC_M_OFF && !mode_wr
      |=> !o_compare_event)
    else $error("event raised by disabled channel");

  cov_fault: cover property (flt_nxt && !flt_r);
  cov_tog: cover property (ctrl_r.compare_mode_field == OCC_M_TOG
    && o_compare_event);
  cov_pulse: cover property (ctrl_r.compare_mode_field == OCC_M_CONT
    && o_compare_event);
  cov_one_shot: cover property (ctrl_r.compare_mode_field == OCC_M_ONE
    && o_compare_event);
  cov_idle_hold: cover property (ctrl_r.idle_stop_select && i_cpu_idle
    && tick);

endmodule

// ### verification/occ_load.sv
// Load on the compare pin and source of the fault line
`timescale 1ns/10ps
module occ_load (
  // Pin side
  input wire logic i_pin,
  input wire logic i_oe_n,
  input wire logic i_fault_req,
  // Levels seen on the board
  output logic o_level,
  output logic o_fault_n
);
  // Pull-down holds the line low when released
  assign o_level = i_oe_n ? 1'b0 : i_pin;
  // Open-drain fault sensor with pull-up
  assign o_fault_n = ~i_fault_req;
endmodule

// ### verification/tb_occ_channel.sv
// Self-checking bench for the output compare channel
`timescale 1ns/10ps
module tb_occ_channel import occ_pkg::*;;
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_cpu_idle = 1'b0;
  logic flt_req = 1'b0;
  logic [1:0] i_addr = 2'h0;
  logic [15:0] i_wdata = 16'h0000;
  occ_timer_t t1 = '0;
  occ_timer_t t2 = '0;
  logic [15:0] rdata;
  logic pin, oe_n, ev, lvl, flt_n;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  // Rows: mode, level after write, level after match, event
  logic [5:0] rows [8] = '{6'b000_0_0_0, 6'b001_0_1_1, 6'b010_1_0_1,
    6'b011_0_1_1, 6'b100_0_1_0, 6'b101_0_1_0, 6'b110_1_0_0, 6'b111_1_0_0};

  occ_channel dut_u (.i_mclk(i_mclk), .i_srst(i_srst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
    .i_first_timer(t1), .i_second_timer(t2), .i_cpu_idle(i_cpu_idle),
    .i_fault_input_a_n(flt_n), .o_compare_output_pin(pin),
    .o_compare_output_pin_oe_n(oe_n), .o_compare_event(ev));
  occ_load load_u (.i_pin(pin), .i_oe_n(oe_n), .i_fault_req(flt_req),
    .o_level(lvl), .o_fault_n(flt_n));

  always #5 i_mclk = ~i_mclk;

  task close_out();
    $display("Checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      close_out();
    end
  end

  task cmp_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  task cmp_bit(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %b got %b", nm, e, g);
    end
  endtask

  task wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  task rd(input logic [1:0] a, input logic [15:0] e);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 cmp_word("rdata", e, rdata);
  endtask

  // Ticks only come from here, so timers are idle during writes
  task tick(input logic sel, input logic [15:0] c);
    @(posedge i_mclk);
    if (sel) begin
      t2.tick <= 1'b1;
      t2.count <= c;
    end else begin
      t1.tick <= 1'b1;
      t1.count <= c;
    end
    @(posedge i_mclk);
    t1.tick <= 1'b0;
    t2.tick <= 1'b0;
    #1;
  endtask

  task pins(input logic ep, input logic eo, input logic ee);
    #1;
    cmp_bit("level", ep, lvl);
    cmp_bit("oe_n", eo, oe_n);
    cmp_bit("event", ee, ev);
  endtask

  initial begin
    int n;
    repeat (4) @(posedge i_mclk);
    i_srst <= 1'b0;
    rd(OCC_ADDR_CTRL, OCC_CTRL_RESET);
    pins(1'b0, 1'b1, 1'b0);
    foreach (rows[i]) begin
      wr(OCC_ADDR_PRI, 16'h000a);
      wr(OCC_ADDR_CTRL, {13'h0, rows[i][5:3]});
      pins(rows[i][2], rows[i][5:3] == 3'h0, 1'b0);
      tick(1'b0, 16'h000a);
      pins(rows[i][1], rows[i][5:3] == 3'h0, rows[i][0]);
    end
    // Time base selection and exact count
    wr(OCC_ADDR_CTRL, 16'h0009);
    tick(1'b0, 16'h000a);
    tick(1'b1, 16'h0009);
    pins(1'b0, 1'b0, 1'b0);
    tick(1'b1, 16'h000a);
    pins(1'b1, 1'b0, 1'b1);
    // Idle behaviour with the stop bit clear, then set
    @(posedge i_mclk) i_cpu_idle <= 1'b1;
    wr(OCC_ADDR_CTRL, 16'h0001);
    tick(1'b0, 16'h000a);
    pins(1'b1, 1'b0, 1'b1);
    wr(OCC_ADDR_CTRL, 16'h2001);
    tick(1'b0, 16'h000a);
    pins(1'b0, 1'b0, 1'b0);
    @(posedge i_mclk) i_cpu_idle <= 1'b0;
    tick(1'b0, 16'h000a);
    pins(1'b1, 1'b0, 1'b1);
    // Unwritable bits and unmapped index
    wr(OCC_ADDR_CTRL, 16'hffff);
    rd(OCC_ADDR_CTRL, 16'h200f);
    wr(2'h3, 16'h0001);
    rd(OCC_ADDR_CTRL, 16'h200f);
    rd(2'h3, 16'h0000);
    // Fault ignored without fault monitoring
    wr(OCC_ADDR_CTRL, 16'h0016);
    rd(OCC_ADDR_CTRL, 16'h0006);
    @(posedge i_mclk) flt_req <= 1'b1;
    repeat (6) begin
      @(posedge i_mclk);
      #1 cmp_bit("event", 1'b0, ev);
    end
    rd(OCC_ADDR_CTRL, 16'h0006);
    @(posedge i_mclk) flt_req <= 1'b0;
    // Fault monitored: flag, release and event
    wr(OCC_ADDR_CTRL, 16'h0007);
    repeat (4) @(posedge i_mclk);
    flt_req <= 1'b1;
    n = 0;
    while (ev !== 1'b1 && n < 8) begin
      @(posedge i_mclk);
      #1 n++;
    end
    cmp_bit("event", 1'b1, ev);
    @(posedge i_mclk);
    pins(1'b0, 1'b1, 1'b0);
    rd(OCC_ADDR_CTRL, 16'h0017);
    @(posedge i_mclk) flt_req <= 1'b0;
    // Zero duty start level
    wr(OCC_ADDR_PRI, 16'h0000);
    wr(OCC_ADDR_CTRL, 16'h0006);
    pins(1'b0, 1'b0, 1'b0);
    // Period match restarts the duty cycle
    wr(OCC_ADDR_PRI, 16'h000a);
    @(posedge i_mclk) t1.period <= 16'h0014;
    tick(1'b0, 16'h0014);
    pins(1'b1, 1'b0, 1'b0);
    tick(1'b0, 16'h000a);
    pins(1'b0, 1'b0, 1'b0);
    // Single and continuous pulses
    wr(OCC_ADDR_PRI, 16'h000a);
    wr(OCC_ADDR_SEC, 16'h0014);
    for (int m = 4; m < 6; m++) begin
      wr(OCC_ADDR_CTRL, m[15:0]);
      tick(1'b0, 16'h000a);
      pins(1'b1, 1'b0, 1'b0);
      tick(1'b0, 16'h0014);
      pins(1'b0, 1'b0, 1'b1);
      tick(1'b0, 16'h000a);
      pins(m == 5, 1'b0, 1'b0);
    end
    close_out();
  end
endmodule
